//--- core/input_sync3.sv
// Three-flop synchroniser that accepts a change once stages two and three agree
`default_nettype none
module input_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output var logic [WIDTH-1:0] o_stable
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] stable_reg;

  // Shift chain, first stage read only by the second
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Hold the old level until stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      stable_reg <= '0;
    end else begin
      stable_reg <= (s2_reg & s3_reg) | (stable_reg & (s2_reg | s3_reg));
    end
  end

  assign o_stable = stable_reg;
endmodule // input_sync3
`default_nettype wire

//--- core/interlock_pulse_driver.sv
// Interlock output driver: timed pulse or toggle on each command
`default_nettype none
module interlock_pulse_driver #(
  parameter int PULSE_CYCLES = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_fire,
  input wire logic i_toggle_mode,
  output var logic o_level
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  logic [CW-1:0] count_reg;
  logic level_reg;

  // Pulse holds for PULSE_CYCLES edges, a new command restarts it
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_reg <= '0;
      level_reg <= 1'b0;
    end else if (i_fire && i_toggle_mode) begin
      count_reg <= '0;
      level_reg <= ~level_reg;
    end else if (i_fire) begin
      count_reg <= CW'(PULSE_CYCLES);
      level_reg <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
      if (count_reg == CW'(1)) begin
        level_reg <= 1'b0;
      end
    end
  end

  assign o_level = level_reg;
endmodule // interlock_pulse_driver
`default_nettype wire

//--- core/slot_hotplug_event_controller.sv
// Slot hot-plug controller: sensors, power, interlock and event signalling
//
// Our own choices: the strobed register port and the address map.
`default_nettype none
`include "hotplug_consts.svh"
module slot_hotplug_event_controller #(
  parameter int ILOCK_PULSE_CYCLES = `ILOCK_PULSE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_eeprom_done,
  input wire hotplug_pkg::addr_type i_addr,
  input wire hotplug_pkg::word_type i_wdata,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  output var hotplug_pkg::word_type o_rdata,
  input wire hotplug_pkg::port_vec_type i_button_input,
  input wire hotplug_pkg::port_vec_type i_presence_input,
  input wire hotplug_pkg::port_vec_type i_power_fault_input,
  input wire hotplug_pkg::port_vec_type i_latch_sensor_input,
  output var hotplug_pkg::port_vec_type o_slot_power_output,
  output var hotplug_pkg::port_vec_type o_interlock_output,
  output var hotplug_pkg::port_vec_type o_msi_req,
  output var hotplug_pkg::port_vec_type o_intx_assert,
  output var hotplug_pkg::port_vec_type o_pme_req,
  output var logic o_general_event_output,
  output var logic o_gpio7_out,
  output var logic o_gpio7_oe
);
  import hotplug_pkg::*;

  // ------------------------------------------------------------
  // Decode helper
  // ------------------------------------------------------------

  // True when the address names register off of port p
  function automatic logic port_hit(input addr_type a, input int p,
                                    input addr_type off);
    return a == addr_type'(`PORT_BASE + (p << `PORT_SHIFT) + off);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  init_state_type state_reg;
  logic [2:0] hp_cfg_reg;
  logic [6:0] pwr_gpio_reg;
  port_vec_type gev_ctl_reg;
  port_vec_type gev_sts_reg;
  port_vec_type gev_sts_next;
  logic [7:0] slot_cap_reg [`NUM_PORTS];
  logic [`CTL_W-1:0] slot_ctl_reg [`NUM_PORTS];
  logic [4:0] evt_flag_reg [`NUM_PORTS];
  logic [4:0] evt_flag_next [`NUM_PORTS];
  logic [4:0] pend_prev_reg [`NUM_PORTS];
  logic [4:0] pend [`NUM_PORTS];
  port_vec_type msi_en_reg;
  port_vec_type intx_dis_reg;
  port_vec_type hpc_prev_reg;
  port_vec_type btn_s, pres_s, fault_s, latch_s;
  port_vec_type btn_prev_reg, pres_prev_reg, fault_prev_reg, latch_prev_reg;
  port_vec_type active, wr_ctl, ilock_fire, ilock_level, auto_off;
  port_vec_type int_fire, pme_fire, gev_fire, intx_level;
  port_vec_type power_reg, msi_req_reg, pme_req_reg, intx_reg;
  logic gev_out_reg;
  logic gpio_out_reg;
  logic gpio_oe_reg;
  word_type rd_word;
  word_type rdata_reg;

  // ------------------------------------------------------------
  // Sensor inputs from the expander side
  // ------------------------------------------------------------

  // All sensor lines cross into the clock domain together
  input_sync3 #(
    .WIDTH(4 * `NUM_PORTS)
  ) u_sensor_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async({i_button_input, i_presence_input, i_power_fault_input,
              i_latch_sensor_input}),
    .o_stable({btn_s, pres_s, fault_s, latch_s})
  );

  // Previous samples; always tracked so the first sample is a capture
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      btn_prev_reg <= '0;
      pres_prev_reg <= '0;
      fault_prev_reg <= '0;
      latch_prev_reg <= '0;
      hpc_prev_reg <= '0;
    end else begin
      btn_prev_reg <= btn_s;
      pres_prev_reg <= pres_s;
      fault_prev_reg <= fault_s;
      latch_prev_reg <= latch_s;
      for (int p = 0; p < `NUM_PORTS; p++) begin
        hpc_prev_reg[p] <= slot_cap_reg[p][`CAP_HPC];
      end
    end
  end

  // ------------------------------------------------------------
  // Expander start-up sequence
  // ------------------------------------------------------------

  // Wait for register loading, take one capture pass, then run
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= ST_LOAD_WAIT;
    end else begin
      case (state_reg)
        ST_LOAD_WAIT: begin
          if (i_eeprom_done) begin
            state_reg <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_LOAD_WAIT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Per-port event and output logic
  // ------------------------------------------------------------

  // Event sources, masking and routing for each port
  always_comb begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      // Port counts events only once its capability has stood a cycle
      active[p] = (state_reg == ST_RUN) && slot_cap_reg[p][`CAP_HPC]
                  && hpc_prev_reg[p];
      wr_ctl[p] = i_wr_strobe && port_hit(i_addr, p, `REG_SLOT_CTL);
      ilock_fire[p] = wr_ctl[p] && i_wdata[`CTL_EIC];
      auto_off[p] = hp_cfg_reg[`CFG_LATCH_OFF]
                    && slot_cap_reg[p][`CAP_LATCH_PRESENT] && latch_s[p];
      evt_flag_next[p] = evt_flag_reg[p];
      if (i_wr_strobe && port_hit(i_addr, p, `REG_SLOT_STS)) begin
        evt_flag_next[p] = evt_flag_reg[p] & ~i_wdata[4:0];
      end
      if (active[p]) begin
        // Set wins over a clear in the same cycle
        evt_flag_next[p][`EVT_ABP] = evt_flag_next[p][`EVT_ABP]
                                     | (btn_s[p] & ~btn_prev_reg[p]);
        evt_flag_next[p][`EVT_PFD] = evt_flag_next[p][`EVT_PFD]
                                     | (fault_s[p] & ~fault_prev_reg[p]);
        evt_flag_next[p][`EVT_LATCH_SENSOR_CHANGED_FLAG] = evt_flag_next[p][`EVT_LATCH_SENSOR_CHANGED_FLAG]
                                       | (~hp_cfg_reg[`CFG_LATCH_AS_ILOCK]
                                          & (latch_s[p] ^ latch_prev_reg[p]));
        evt_flag_next[p][`EVT_PDC] = evt_flag_next[p][`EVT_PDC]
                                     | (pres_s[p] ^ pres_prev_reg[p]);
        evt_flag_next[p][`EVT_CC] = evt_flag_next[p][`EVT_CC] | wr_ctl[p];
      end
      // Unmasked flags and their rising edges
      pend[p] = evt_flag_reg[p] & slot_ctl_reg[p][4:0];
      int_fire[p] = (|(pend[p] & ~pend_prev_reg[p]))
                    && slot_ctl_reg[p][`CTL_HOTPLUG_INTERRUPT_GATE] && !gev_ctl_reg[p];
      pme_fire[p] = (pwr_gpio_reg[p] || pwr_gpio_reg[`PG_D3HOT_SW])
                    && (|(pend[p] & ~pend_prev_reg[p] & 5'h0f))
                    && !gev_ctl_reg[p];
      gev_fire[p] = (|(pend[p] & ~pend_prev_reg[p])) && gev_ctl_reg[p];
      intx_level[p] = (|pend[p]) && slot_ctl_reg[p][`CTL_HOTPLUG_INTERRUPT_GATE]
                      && !gev_ctl_reg[p] && !msi_en_reg[p]
                      && !intx_dis_reg[p];
    end
  end

  // Sticky slot status flags and edge history
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (i_reset) begin
        evt_flag_reg[p] <= '0;
        pend_prev_reg[p] <= '0;
      end else begin
        evt_flag_reg[p] <= evt_flag_next[p];
        pend_prev_reg[p] <= pend[p];
      end
    end
  end

  // Slot power follows power control unless the open latch forces off
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      power_reg <= '0;
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        power_reg[p] <= !slot_ctl_reg[p][`CTL_PCC] && !auto_off[p];
      end
    end
  end

  // Interlock drivers, one per port
  for (genvar g = 0; g < `NUM_PORTS; g++) begin : g_ilock
    interlock_pulse_driver #(
      .PULSE_CYCLES(ILOCK_PULSE_CYCLES)
    ) u_ilock (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_fire(ilock_fire[g]),
      .i_toggle_mode(hp_cfg_reg[`CFG_ILOCK_TOGGLE]),
      .o_level(ilock_level[g])
    );
  end

  // Interrupt and wake-up requests
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      msi_req_reg <= '0;
      pme_req_reg <= '0;
      intx_reg <= '0;
    end else begin
      msi_req_reg <= int_fire & msi_en_reg;
      pme_req_reg <= pme_fire;
      intx_reg <= intx_level;
    end
  end

  // ------------------------------------------------------------
  // General event path
  // ------------------------------------------------------------

  // Status clears by write-one, a new event in that cycle wins
  always_comb begin
    gev_sts_next = gev_sts_reg;
    if (i_wr_strobe && i_addr == `REG_GEV_STS) begin
      gev_sts_next = gev_sts_reg & ~i_wdata[`NUM_PORTS-1:0];
    end
    gev_sts_next = gev_sts_next | gev_fire;
  end

  // Event output and shared pin seven
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      gev_sts_reg <= '0;
      gev_out_reg <= 1'b0;
      gpio_out_reg <= 1'b0;
      gpio_oe_reg <= 1'b0;
    end else begin
      gev_sts_reg <= gev_sts_next;
      gev_out_reg <= |gev_sts_next;
      if (pwr_gpio_reg[`PG_GPIO7_ALT]) begin
        gpio_out_reg <= |gev_sts_next;
        gpio_oe_reg <= 1'b1;
      end else begin
        gpio_out_reg <= pwr_gpio_reg[`PG_GPIO7_DATA];
        gpio_oe_reg <= pwr_gpio_reg[`PG_GPIO7_DIR];
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------

  // Global configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      hp_cfg_reg <= `HP_CONFIG_RST;
      pwr_gpio_reg <= `PWR_GPIO_RST;
      gev_ctl_reg <= '0;
    end else if (i_wr_strobe) begin
      case (i_addr)
        `REG_HP_CONFIG: hp_cfg_reg <= i_wdata[2:0];
        `REG_PWR_GPIO: pwr_gpio_reg <= i_wdata[6:0];
        `REG_GEV_CTL: gev_ctl_reg <= i_wdata[`NUM_PORTS-1:0];
        default: hp_cfg_reg <= hp_cfg_reg;
      endcase
    end
  end

  // Per-port capability, control, MSI and command registers
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (i_reset) begin
        slot_cap_reg[p] <= `SLOT_CAP_RST;
        slot_ctl_reg[p] <= `SLOT_CTL_RST;
        msi_en_reg[p] <= 1'b0;
        intx_dis_reg[p] <= 1'b0;
      end else if (i_wr_strobe) begin
        if (port_hit(i_addr, p, `REG_SLOT_CAP)) begin
          slot_cap_reg[p] <= i_wdata[7:0];
        end
        if (port_hit(i_addr, p, `REG_SLOT_CTL)) begin
          // Command bit is a pulse and never stored
          slot_ctl_reg[p] <= {1'b0, i_wdata[`CTL_W-2:0]};
        end
        if (port_hit(i_addr, p, `REG_MSI_CAP)) begin
          msi_en_reg[p] <= i_wdata[`MSI_EN];
        end
        if (port_hit(i_addr, p, `REG_COMMAND)) begin
          intx_dis_reg[p] <= i_wdata[`CMD_LEGACY_IRQ_DISABLE];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    case (i_addr)
      `REG_HP_CONFIG: rd_word[2:0] = hp_cfg_reg;
      `REG_PWR_GPIO: rd_word[6:0] = pwr_gpio_reg;
      `REG_GEV_CTL: rd_word[`NUM_PORTS-1:0] = gev_ctl_reg;
      `REG_GEV_STS: rd_word[`NUM_PORTS-1:0] = gev_sts_reg;
      default: rd_word = '0;
    endcase
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (port_hit(i_addr, p, `REG_SLOT_CAP)) begin
        rd_word[7:0] = slot_cap_reg[p];
      end
      if (port_hit(i_addr, p, `REG_SLOT_CTL)) begin
        rd_word[`CTL_W-1:0] = slot_ctl_reg[p];
      end
      if (port_hit(i_addr, p, `REG_SLOT_STS)) begin
        rd_word[4:0] = evt_flag_reg[p];
        rd_word[6] = pres_s[p];
        if (hp_cfg_reg[`CFG_LATCH_AS_ILOCK]) begin
          rd_word[5] = 1'b0;
          rd_word[7] = latch_s[p];
        end else begin
          rd_word[5] = latch_s[p];
          rd_word[7] = ilock_level[p];
        end
      end
      if (port_hit(i_addr, p, `REG_MSI_CAP)) begin
        rd_word[`MSI_EN] = msi_en_reg[p];
      end
      if (port_hit(i_addr, p, `REG_COMMAND)) begin
        rd_word[`CMD_LEGACY_IRQ_DISABLE] = intx_dis_reg[p];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_rd_strobe ? rd_word : '0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_rdata = rdata_reg;
  assign o_slot_power_output = power_reg;
  assign o_interlock_output = ilock_level;
  assign o_msi_req = msi_req_reg;
  assign o_pme_req = pme_req_reg;
  assign o_intx_assert = intx_reg;
  assign o_general_event_output = gev_out_reg;
  assign o_gpio7_out = gpio_out_reg;
  assign o_gpio7_oe = gpio_oe_reg;
endmodule // slot_hotplug_event_controller
`default_nettype wire

//--- pkg/hotplug_consts.svh
// Register map, field positions, reset values and timing counts
`ifndef HOTPLUG_CONSTS_SVH
`define HOTPLUG_CONSTS_SVH

// Sizes
`define NUM_PORTS 3
`define ADDR_W 8
`define CTL_W 12

// Global registers
`define REG_HP_CONFIG 8'h00
`define REG_GEV_CTL 8'h04
`define REG_GEV_STS 8'h08
`define REG_PWR_GPIO 8'h0c

// Per-port block: base + port * stride + offset
`define PORT_BASE 8'h20
`define PORT_SHIFT 5
`define REG_SLOT_CAP 8'h00
`define REG_SLOT_CTL 8'h04
`define REG_SLOT_STS 8'h08
`define REG_MSI_CAP 8'h0c
`define REG_COMMAND 8'h10

// Fields
`define CFG_LATCH_AS_ILOCK 0
`define CFG_LATCH_OFF 1
`define CFG_ILOCK_TOGGLE 2
`define PG_D3HOT_SW 3
`define PG_GPIO7_ALT 4
`define PG_GPIO7_DATA 5
`define PG_GPIO7_DIR 6
`define CAP_LATCH_PRESENT 2
`define CAP_HPC 6
`define CTL_HOTPLUG_INTERRUPT_GATE 5
`define CTL_PCC 10
`define CTL_EIC 11
`define EVT_ABP 0
`define EVT_PFD 1
`define EVT_LATCH_SENSOR_CHANGED_FLAG 2
`define EVT_PDC 3
`define EVT_CC 4
`define MSI_EN 16
`define CMD_LEGACY_IRQ_DISABLE 10

// Reset values
`define HP_CONFIG_RST 3'h0
`define PWR_GPIO_RST 7'h00
`define SLOT_CAP_RST 8'h44
`define SLOT_CTL_RST 12'h400

// Interlock pulse timing
`define ILOCK_MIN_MS 100
`define ILOCK_MAX_MS 150
`define SYS_CLK_KHZ 50000
`define ILOCK_PULSE_CYC (((`ILOCK_MIN_MS + `ILOCK_MAX_MS) / 2) * `SYS_CLK_KHZ)

`endif

//--- pkg/hotplug_pkg.sv
// Types shared by the hot-plug event controller
`default_nettype none
`include "hotplug_consts.svh"
package hotplug_pkg;
  typedef logic [`NUM_PORTS-1:0] port_vec_type;
  typedef logic [`ADDR_W-1:0] addr_type;
  typedef logic [31:0] word_type;
  typedef enum logic [1:0] {ST_LOAD_WAIT, ST_CAPTURE, ST_RUN} init_state_type;
endpackage
`default_nettype wire

//--- sim/slot_hotplug_checker_sva.sv
// Checker: concurrent assertions on the hot-plug controller ports
`default_nettype none
`include "hotplug_consts.svh"
module slot_hotplug_checker #(
  parameter int ILOCK_PULSE_CYCLES = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire hotplug_pkg::addr_type i_addr,
  input wire hotplug_pkg::word_type i_wdata,
  input wire logic i_wr_strobe,
  input wire hotplug_pkg::port_vec_type i_latch_sensor_input,
  input wire hotplug_pkg::port_vec_type o_slot_power_output,
  input wire hotplug_pkg::port_vec_type o_interlock_output,
  input wire hotplug_pkg::port_vec_type o_msi_req,
  input wire hotplug_pkg::port_vec_type o_intx_assert,
  input wire hotplug_pkg::port_vec_type o_pme_req,
  input wire logic o_general_event_output,
  input wire logic o_gpio7_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import hotplug_pkg::*;
  // ----
  // Shadow settings
  // ----
  logic [2:0] cfg_q;
  port_vec_type gev_q;
  logic alt_q;
  int hi_cnt;
  logic [3:0] lat_cnt;
  logic ctl0_wr;
  logic gsts_wr;
  assign ctl0_wr = i_wr_strobe && (i_addr == `PORT_BASE + `REG_SLOT_CTL);
  assign gsts_wr = i_wr_strobe && (i_addr == `REG_GEV_STS);
  // Track configuration writes
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cfg_q <= '0;
      gev_q <= '0;
      alt_q <= 1'b0;
    end else if (i_wr_strobe) begin
      if (i_addr == `REG_HP_CONFIG) cfg_q <= i_wdata[2:0];
      if (i_addr == `REG_GEV_CTL) gev_q <= i_wdata[`NUM_PORTS-1:0];
      if (i_addr == `REG_PWR_GPIO) alt_q <= i_wdata[`PG_GPIO7_ALT];
    end
  end
  // Interlock high time and latch open time on port 0
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || ctl0_wr || cfg_q[2] || !o_interlock_output[0]) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
    if (i_reset || !i_latch_sensor_input[0]) lat_cnt <= 4'h0;
    else if (lat_cnt != 4'hf) lat_cnt <= lat_cnt + 4'h1;
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_latch_cuts_power: assert property (
    cfg_q[1] && $past(cfg_q[1], 2) && lat_cnt == 4'hf |-> !o_slot_power_output[0])
    else $error("slot power on with latch open");
  a_pcc_power_off: assert property (
    ctl0_wr && i_wdata[`CTL_PCC] |-> ##2 !o_slot_power_output[0])
    else $error("slot power on after power control set");
  a_msi_intx_excl: assert property ((o_msi_req & o_intx_assert) == '0)
    else $error("msi and intx together");
  a_gev_quiet_ports: assert property (
    ((gev_q & $past(gev_q) & $past(gev_q, 2) & $past(gev_q, 3))
     & (o_msi_req | o_pme_req | o_intx_assert)) == '0)
    else $error("general event port raised a request");
  a_gpio_follows_gev: assert property (
    alt_q && $past(alt_q, 2) |-> o_gpio7_out == o_general_event_output)
    else $error("pin seven differs from general event");
  a_gev_fall_cause: assert property (
    $fell(o_general_event_output) |-> $past(gsts_wr) || $past(gsts_wr, 2))
    else $error("general event fell without clear");
  a_ilock_pulse_start: assert property (
    ctl0_wr && i_wdata[`CTL_EIC] && !cfg_q[2] |=> o_interlock_output[0])
    else $error("interlock pulse did not start");
  a_ilock_pulse_len: assert property (hi_cnt <= ILOCK_PULSE_CYCLES)
    else $error("interlock pulse too long");
endmodule // slot_hotplug_checker

bind slot_hotplug_event_controller slot_hotplug_checker #(
  .ILOCK_PULSE_CYCLES(ILOCK_PULSE_CYCLES)
) u_chk (
  .i_sys_clk(i_sys_clk),
  .i_reset(i_reset),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr_strobe(i_wr_strobe),
  .i_latch_sensor_input(i_latch_sensor_input),
  .o_slot_power_output(o_slot_power_output),
  .o_interlock_output(o_interlock_output),
  .o_msi_req(o_msi_req),
  .o_intx_assert(o_intx_assert),
  .o_pme_req(o_pme_req),
  .o_general_event_output(o_general_event_output),
  .o_gpio7_out(o_gpio7_out)
);
`default_nettype wire

//--- sim/slot_sensor_model.sv
// Slot sensor model: button, presence, power fault and latch per port
`default_nettype none
module slot_sensor_model (
  input wire logic i_sys_clk,
  input wire hotplug_pkg::port_vec_type i_slot_power_output,
  output var hotplug_pkg::port_vec_type o_button,
  output var hotplug_pkg::port_vec_type o_presence,
  output var hotplug_pkg::port_vec_type o_power_fault,
  output var hotplug_pkg::port_vec_type o_latch
);
  timeunit 1ns;
  timeprecision 1ns;
  import hotplug_pkg::*;
  port_vec_type pwr_q;
  // Card in port 1 from power-up, everything else idle
  initial begin
    o_button = '0;
    o_presence = 3'h2;
    o_power_fault = '0;
    o_latch = '0;
    pwr_q = '0;
  end
  // Fault stays until the slot power output changes
  always @(posedge i_sys_clk) begin
    pwr_q <= i_slot_power_output;
    if (pwr_q != i_slot_power_output)
      o_power_fault <= o_power_fault & ~(pwr_q ^ i_slot_power_output);
  end
  // Button held for hold cycles
  task automatic press(input int p, input int hold);
    @(posedge i_sys_clk);
    o_button[p] <= 1'b1;
    repeat (hold) @(posedge i_sys_clk);
    o_button[p] <= 1'b0;
  endtask
  task automatic fault(input int p);
    @(posedge i_sys_clk);
    o_power_fault[p] <= 1'b1;
  endtask
  task automatic set_latch(input int p, input logic v);
    @(posedge i_sys_clk);
    o_latch[p] <= v;
  endtask
  task automatic set_presence(input int p, input logic v);
    @(posedge i_sys_clk);
    o_presence[p] <= v;
  endtask
endmodule // slot_sensor_model
`default_nettype wire

//--- sim/tb_slot_hotplug_event_controller.sv
// Testbench for the slot hot-plug event controller
`default_nettype none
`include "hotplug_consts.svh"
module tb_slot_hotplug_event_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import hotplug_pkg::*;
  logic clk, rst, done, wr, rd, clr, gev, g7o, g7oe;
  addr_type addr;
  word_type wdata, rdata;
  port_vec_type btn, pres, flt, lat, pwr, ilk, msi, intx, pme, msi_seen, pme_seen;
  int hi_len, bad_count, checks;
  word_type ctl_tab[3] = '{32'h11, 32'h21, 32'h20};
  word_type pme_tab[3] = '{32'h1, 32'h1, 32'h0};
  word_type irq_tab[3] = '{32'h0, 32'h1, 32'h0};
  // ----
  // Design, sensors, clock, monitors
  // ----
  slot_hotplug_event_controller #(.ILOCK_PULSE_CYCLES(20)) dut (
    .i_sys_clk(clk), .i_reset(rst), .i_eeprom_done(done), .i_addr(addr),
    .i_wdata(wdata), .i_wr_strobe(wr), .i_rd_strobe(rd), .o_rdata(rdata),
    .i_button_input(btn), .i_presence_input(pres), .i_power_fault_input(flt),
    .i_latch_sensor_input(lat), .o_slot_power_output(pwr), .o_interlock_output(ilk),
    .o_msi_req(msi), .o_intx_assert(intx), .o_pme_req(pme),
    .o_general_event_output(gev), .o_gpio7_out(g7o), .o_gpio7_oe(g7oe));
  slot_sensor_model sensors (.i_sys_clk(clk), .i_slot_power_output(pwr), .o_button(btn),
    .o_presence(pres), .o_power_fault(flt), .o_latch(lat));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Catch request pulses, time the interlock
  always @(posedge clk) begin
    msi_seen <= clr ? '0 : msi_seen | msi;
    pme_seen <= clr ? '0 : pme_seen | pme;
    hi_len <= clr ? 0 : hi_len + int'(ilk[0]);
  end
  // ----
  // Bus and check tasks
  // ----
  function automatic addr_type pa(input int p, input addr_type off);
    return addr_type'(`PORT_BASE + (p << `PORT_SHIFT) + off);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input addr_type a, input word_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk(input word_type seen, input word_type exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input addr_type a, input word_type m, input word_type e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e);
  endtask
  task automatic clr_seen();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  // ----
  // Test sequence
  // ----
  initial begin
    {rst, done, wr, rd, clr, addr, wdata, hi_len, bad_count, checks, msi_seen, pme_seen} = '0;
    rst = 1'b1;
    tick(20);
    rst <= 1'b0;
    tick(2);
    rc(pa(0, `REG_SLOT_CAP), '1, 32'h44);
    rc(pa(0, `REG_SLOT_CTL), '1, 32'h400);
    rc(8'h18, '1, 32'h0);
    rc(pa(0, `REG_SLOT_STS), 32'h10, 32'h0);
    chk(pwr, 32'h0);
    done <= 1'b1;
    tick(10);
    rc(pa(1, `REG_SLOT_STS), 32'h58, 32'h40);
    $display("test reset done");
    wr_reg(pa(0, `REG_SLOT_CTL), 32'h0);
    tick(3);
    chk(pwr[0], 32'h1);
    wr_reg(`REG_HP_CONFIG, 32'h2);
    sensors.set_latch(0, 1'b1);
    tick(12);
    chk(pwr[0], 32'h0);
    rc(pa(0, `REG_SLOT_STS), 32'ha0, 32'h20);
    wr_reg(`REG_HP_CONFIG, 32'h1);
    tick(3);
    rc(pa(0, `REG_SLOT_STS), 32'ha0, 32'h80);
    chk(pwr[0], 32'h1);
    sensors.set_latch(0, 1'b0);
    wr_reg(`REG_HP_CONFIG, 32'h0);
    $display("test latch done");
    clr_seen();
    wr_reg(pa(0, `REG_SLOT_CTL), 32'hc00);
    rc(pa(0, `REG_SLOT_STS), 32'h80, 32'h80);
    tick(30);
    chk(hi_len, 32'h14);
    chk(pwr[0], 32'h0);
    rc(pa(0, `REG_SLOT_STS), 32'h80, 32'h0);
    wr_reg(`REG_HP_CONFIG, 32'h4);
    wr_reg(pa(0, `REG_SLOT_CTL), 32'h800);
    tick(30);
    chk(ilk[0], 32'h1);
    wr_reg(pa(0, `REG_SLOT_CTL), 32'h800);
    tick(3);
    chk(ilk[0], 32'h0);
    wr_reg(`REG_HP_CONFIG, 32'h0);
    $display("test interlock done");
    wr_reg(pa(0, `REG_MSI_CAP), 32'h10000);
    wr_reg(pa(0, `REG_SLOT_STS), 32'h1f);
    clr_seen();
    wr_reg(pa(0, `REG_SLOT_CTL), 32'h10);
    tick(6);
    chk(msi_seen[0] | intx[0], 32'h0);
    wr_reg(pa(0, `REG_SLOT_STS), 32'h1f);
    wr_reg(pa(0, `REG_SLOT_CTL), 32'h30);
    tick(6);
    chk(msi_seen[0], 32'h1);
    chk(intx[0], 32'h0);
    $display("test msi done");
    wr_reg(pa(1, `REG_SLOT_CTL), 32'h43f);
    tick(4);
    chk(intx[1], 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr_reg(pa(1, `REG_SLOT_STS), 32'h1f);
      tick(4);
      chk(intx[1], 32'h0);
      case (k)
        0: sensors.press(1, 2);
        1: sensors.fault(1);
        2: sensors.set_latch(1, 1'b1);
        default: sensors.set_presence(1, 1'b0);
      endcase
      tick(12);
      rc(pa(1, `REG_SLOT_STS), 32'h1 << k, 32'h1 << k);
      chk(intx[1], 32'h1);
    end
    wr_reg(pa(1, `REG_SLOT_STS), 32'h1f);
    wr_reg(pa(1, `REG_COMMAND), 32'h400);
    wr_reg(pa(1, `REG_SLOT_CTL), 32'h43f);
    tick(6);
    chk(intx[1], 32'h0);
    $display("test legacy done");
    wr_reg(`REG_PWR_GPIO, 32'h4);
    for (int m = 0; m < 3; m++) begin
      wr_reg(pa(2, `REG_SLOT_STS), 32'h1f);
      clr_seen();
      wr_reg(pa(2, `REG_SLOT_CTL), ctl_tab[m]);
      tick(6);
      chk(pme_seen[2], 32'h0);
      sensors.press(2, 6);
      tick(12);
      chk(pme_seen[2], pme_tab[m]);
      chk(intx[2], irq_tab[m]);
    end
    $display("test wake done");
    wr_reg(`REG_PWR_GPIO, 32'h14);
    wr_reg(`REG_GEV_CTL, 32'h4);
    wr_reg(pa(2, `REG_SLOT_CTL), 32'h21);
    for (int a = 1; a >= 0; a--) begin
      wr_reg(pa(2, `REG_SLOT_STS), 32'h1f);
      wr_reg(`REG_GEV_STS, 32'h7);
      clr_seen();
      sensors.press(2, 3);
      tick(12);
      chk(gev, 32'h1);
      chk(g7o, word_type'(a));
      chk(g7oe, word_type'(a));
      chk(pme_seen[2] | msi_seen[2] | intx[2], 32'h0);
      rc(`REG_GEV_STS, '1, 32'h4);
      rc(pa(2, `REG_SLOT_STS), 32'h1, 32'h1);
      wr_reg(`REG_GEV_STS, 32'h4);
      tick(2);
      chk(gev, 32'h0);
      wr_reg(`REG_PWR_GPIO, 32'h4);
    end
    $display("test general event done");
    finish_test();
  end
endmodule // tb_slot_hotplug_event_controller
`default_nettype wire
